// ### design/fdis_top.sv
// framer and data link one interrupt status block, ahb-lite register access
`timescale 1ns/1ps
module fdis_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // receive framer events
  input  wire logic        crc6ErrorEvt,
  input  wire logic        framingBitErrorEvt,
  // hdlc controller one events
  input  wire logic        txMsgStartEvt,
  input  wire logic        rxMsgStartEvt,
  input  wire logic        txMsgEndEvt,
  input  wire logic        rxMsgCompleteEvt,
  input  wire logic        rxBufferFullEvt,
  input  wire logic        rxMsgKindIn,
  // interrupt
  output logic             irq
);
  import fdis_pkg::*;

  // -----------------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------------
  fdis_regbus_if rb ();

  fdis_ahb_slave u_slave (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rb        (rb.bus)
  );

  // hsize is accepted but unused: only whole-word accesses are meaningful
  wire unusedSize = ^hsize;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire rdFramerStatus   = rb.rdStb & (rb.rdAddr == FRAMER_STATUS_OFS);
  wire rdFramerEnable   = rb.rdStb & (rb.rdAddr == FRAMER_IRQ_ENABLE_OFS);
  wire rdDatalinkStatus = rb.rdStb & (rb.rdAddr == DATALINK_STATUS_ONE_OFS);
  wire rdDatalinkEnable = rb.rdStb & (rb.rdAddr == DATALINK_IRQ_EN_ONE_OFS);
  wire rdIrqPending     = rb.rdStb & (rb.rdAddr == IRQ_PENDING_OFS);

  wire wrFramerEnable   = rb.wrStb & (rb.wrAddr == FRAMER_IRQ_ENABLE_OFS);
  wire wrDatalinkEnable = rb.wrStb & (rb.wrAddr == DATALINK_IRQ_EN_ONE_OFS);
  wire wrFramerClear    = rb.wrStb & (rb.wrAddr == FRAMER_CLEAR_OFS);
  wire wrDatalinkClear  = rb.wrStb & (rb.wrAddr == DATALINK_CLEAR_OFS);

  // -----------------------------------------------------------------
  // enable registers
  // -----------------------------------------------------------------
  logic [FRAMER_EVT_W-1:0]   framer_irq_enable;
  logic [DATALINK_EVT_W-1:0] datalink_irq_enable_one;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      framer_irq_enable <= FRAMER_EN_RST;
    end else if (wrFramerEnable) begin
      framer_irq_enable <= rb.wrData[FRAMER_EVT_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      datalink_irq_enable_one <= DATALINK_EN_RST;
    end else if (wrDatalinkEnable) begin
      datalink_irq_enable_one <= rb.wrData[RX_MSG_FINISHED_BIT +: DATALINK_EVT_W];
    end
  end

  wire crc6_error_irq_en        = framer_irq_enable[CRC6_ERROR_BIT];
  wire framing_bit_error_irq_en = framer_irq_enable[FRAMING_ERROR_BIT];

  // -----------------------------------------------------------------
  // framer event latches
  // -----------------------------------------------------------------
  logic [FRAMER_EVT_W-1:0] framerSet;
  logic [FRAMER_EVT_W-1:0] framerClr;
  logic [FRAMER_EVT_W-1:0] framerStatus;

  // [RQ11] framing error flag source
  assign framerSet[FRAMING_ERROR_BIT] = framingBitErrorEvt;
  // [RQ1] crc-6 error source
  assign framerSet[CRC6_ERROR_BIT]    = crc6ErrorEvt;

  // [RQ8] clear on read, or by clear register
  assign framerClr = (rdFramerStatus ? {FRAMER_EVT_W{1'b1}} : {FRAMER_EVT_W{1'b0}})
                   | (wrFramerClear ? rb.wrData[FRAMER_EVT_W-1:0] : {FRAMER_EVT_W{1'b0}});

  fdis_evt_latch #(.W(FRAMER_EVT_W)) u_framer_evt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .setEvt  (framerSet),
    .clrMask (framerClr),
    .status  (framerStatus)
  );

  // [RQ3] no sync-loss path
  // the framing error flag feeds only its own status bit and the interrupt;
  // frame synchronization state lives in the framer and is never touched here
  wire framing_error_flag = framerStatus[FRAMING_ERROR_BIT];

  // -----------------------------------------------------------------
  // data link one event latches
  // -----------------------------------------------------------------
  logic [DATALINK_EVT_W-1:0] dlSet;
  logic [DATALINK_EVT_W-1:0] dlClr;
  logic [DATALINK_EVT_W-1:0] dlStatus;

  // [RQ5] transmit start
  assign dlSet[TX_MSG_STARTED_BIT - DATALINK_EVT_LSB]  = txMsgStartEvt;
  // [RQ6] receive start
  assign dlSet[RX_MSG_STARTED_BIT - DATALINK_EVT_LSB]  = rxMsgStartEvt;
  // [RQ7] transmit end
  assign dlSet[TX_MSG_FINISHED_BIT - DATALINK_EVT_LSB] = txMsgEndEvt;
  // [RQ12] full message or buffer full
  assign dlSet[RX_MSG_FINISHED_BIT - DATALINK_EVT_LSB] = rxMsgCompleteEvt | rxBufferFullEvt;

  // [RQ8] clear on read, or by clear register
  assign dlClr = (rdDatalinkStatus ? {DATALINK_EVT_W{1'b1}} : {DATALINK_EVT_W{1'b0}})
               | (wrDatalinkClear ? rb.wrData[RX_MSG_FINISHED_BIT +: DATALINK_EVT_W] : {DATALINK_EVT_W{1'b0}});

  fdis_evt_latch #(.W(DATALINK_EVT_W)) u_dl_evt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .setEvt  (dlSet),
    .clrMask (dlClr),
    .status  (dlStatus)
  );

  // -----------------------------------------------------------------
  // message kind
  // -----------------------------------------------------------------
  logic message_kind;

  // [RQ4] kind of last received message
  // taken when a message completes; a buffer-full end leaves the old kind
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      message_kind <= MSG_KIND_RST;
    end else if (rxMsgCompleteEvt) begin
      message_kind <= rxMsgKindIn ? MSG_ORIENTED : BIT_ORIENTED;
    end
  end

  // -----------------------------------------------------------------
  // interrupt
  // -----------------------------------------------------------------
  // [RQ1] crc-6 gated by its enable
  wire crc6Pending    = framerStatus[CRC6_ERROR_BIT] & crc6_error_irq_en;
  // [RQ2] framing error gated by its enable
  wire framingPending = framing_error_flag & framing_bit_error_irq_en;
  wire framerPending  = crc6Pending | framingPending;
  wire dlPending      = |(dlStatus & datalink_irq_enable_one);

  // [RQ13] level while any enabled bit set
  assign irq = framerPending | dlPending;

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  wire [31:0] framerStatusWord = {{(32-FRAMER_EVT_W){1'b0}}, framerStatus};
  wire [31:0] framerEnableWord = {{(32-FRAMER_EVT_W){1'b0}}, framer_irq_enable};
  wire [31:0] dlStatusWord     = {24'h000000, message_kind, dlStatus, 3'h0};
  wire [31:0] dlEnableWord     = {24'h000000, 1'b0, datalink_irq_enable_one, 3'h0};
  wire [31:0] pendingWord      = {30'h00000000, dlPending, framerPending};

  // clear registers and unmapped offsets read as zero
  assign rb.rdData = rdFramerStatus   ? framerStatusWord :
                     rdFramerEnable   ? framerEnableWord :
                     rdDatalinkStatus ? dlStatusWord :
                     rdDatalinkEnable ? dlEnableWord :
                     rdIrqPending     ? pendingWord : 32'h0000_0000;

endmodule : fdis_top

// ### include/fdis_pkg.sv
// constants shared by the framer / data link interrupt status block
// -----------------------------------------------------------------
// What the document asks of this block and of its host
// [RQ1] a crc-6 multiframe error raises the interrupt only while its enable bit 1 is set.
// [RQ2] a framing alignment bit error raises the interrupt only while its enable bit 0 is set.
// [RQ3] a framing alignment bit error is flagged on its own and never counts as loss of sync.
// [RQ4] read-only bit 7 shows the kind of the last received message, 0 bit-oriented, 1 message-oriented.
// [RQ5] the transmit controller sets bit 6 when it starts sending a message.
// [RQ6] the receive controller sets bit 5 when it starts receiving a message.
// [RQ7] the transmit controller sets bit 4 when it has finished sending a message.
// [RQ8] each event bit holds 1 from its event until the register is next read, then reads 0; the code also clears bits written 1 to the clear registers.
// [RQ9] for long messages the host should start filling the next transmit buffer on the start event.
// [RQ10] for long messages the host must finish that buffer before the end-of-transmission event.
// [RQ11] the framer latches a clear-on-read framing error flag at bit 0, gated by its enable.
// [RQ12] the receive controller sets bit 3 when a full message arrived or its buffer is full.
// [RQ13] the interrupt output is high while any set status bit has its enable set.
// -----------------------------------------------------------------
package fdis_pkg;

  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] FRAMER_STATUS_OFS       = 8'h00;
  localparam logic [7:0] FRAMER_IRQ_ENABLE_OFS   = 8'h04;
  localparam logic [7:0] DATALINK_STATUS_ONE_OFS = 8'h08;
  localparam logic [7:0] DATALINK_IRQ_EN_ONE_OFS = 8'h0C;
  localparam logic [7:0] FRAMER_CLEAR_OFS        = 8'h10;
  localparam logic [7:0] DATALINK_CLEAR_OFS      = 8'h14;
  localparam logic [7:0] IRQ_PENDING_OFS         = 8'h18;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int FRAMING_ERROR_BIT   = 0;
  localparam int CRC6_ERROR_BIT      = 1;
  localparam int MESSAGE_KIND_BIT    = 7;
  localparam int TX_MSG_STARTED_BIT  = 6;
  localparam int RX_MSG_STARTED_BIT  = 5;
  localparam int TX_MSG_FINISHED_BIT = 4;
  localparam int RX_MSG_FINISHED_BIT = 3;
  localparam int FRAMER_EVT_W        = 2;
  localparam int DATALINK_EVT_W      = 4;
  localparam int DATALINK_EVT_LSB    = 3;

  // -----------------------------------------------------------------
  // values after reset and message kind encodings
  // -----------------------------------------------------------------
  localparam logic [1:0] FRAMER_EN_RST   = 2'h0;
  localparam logic [3:0] DATALINK_EN_RST = 4'h0;
  localparam logic       MSG_KIND_RST    = 1'b0;
  localparam logic       BIT_ORIENTED    = 1'b0;
  localparam logic       MSG_ORIENTED    = 1'b1;

endpackage : fdis_pkg

// ### include/fdis_regbus_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface fdis_regbus_if;
  logic        rdStb;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        wrStb;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;

  modport bus  (output rdStb, output rdAddr, input rdData, output wrStb, output wrAddr, output wrData);
  modport regs (input rdStb, input rdAddr, output rdData, input wrStb, input wrAddr, input wrData);
endinterface : fdis_regbus_if

// ### design/fdis_ahb_slave.sv
// ahb-lite slave, zero wait states, turns transfers into register strobes
`timescale 1ns/1ps
module fdis_ahb_slave (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  fdis_regbus_if.bus       rb
);
  import fdis_pkg::*;

  // -----------------------------------------------------------------
  // address phase decode
  // -----------------------------------------------------------------
  wire addrPhase = hsel & htrans[1] & hready;

  logic       dataWr;
  logic [7:0] dataAddr;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dataWr   <= 1'b0;
      dataAddr <= 8'h00;
    end else if (hready) begin
      dataWr   <= addrPhase & hwrite;
      dataAddr <= haddr[7:0];
    end
  end

  // reads act at the address phase so clear-on-read and the sampled value agree
  assign rb.rdStb  = addrPhase & ~hwrite;
  assign rb.rdAddr = haddr[7:0];
  assign rb.wrStb  = dataWr;
  assign rb.wrAddr = dataAddr;
  assign rb.wrData = hwdata;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rb.rdStb) begin
      hrdata <= rb.rdData;
    end
  end

  // never stalls, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : fdis_ahb_slave

// ### design/fdis_evt_latch.sv
// sticky event bits with set-over-clear priority
`timescale 1ns/1ps
module fdis_evt_latch #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] setEvt,
  input  wire logic [W-1:0] clrMask,
  output logic [W-1:0]      status
);
  import fdis_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // [RQ8] set beats clear
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          status[i] <= 1'b0;
        end else begin
          status[i] <= setEvt[i] | (status[i] & ~clrMask[i]);
        end
      end
    end
  endgenerate
endmodule : fdis_evt_latch

// ### bench/fdis_chk.sv
// concurrent checks on the top ports of the interrupt status block
`timescale 1ns/1ps
module fdis_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        crc6ErrorEvt,
  input wire logic        framingBitErrorEvt,
  input wire logic        txMsgStartEvt,
  input wire logic        rxMsgStartEvt,
  input wire logic        txMsgEndEvt,
  input wire logic        rxMsgCompleteEvt,
  input wire logic        rxBufferFullEvt,
  input wire logic        irq
);
  // -----------------------------------------------------------------
  // shadow of the enables, rebuilt from bus writes
  // -----------------------------------------------------------------
  logic       wrPend;
  logic       rdPend;
  logic [7:0] phAddr;
  logic [6:0] en;
  wire        take   = hsel && htrans[1] && hready;
  wire        enWr   = wrPend && (phAddr == 8'h04 || phAddr == 8'h0C);
  wire  [1:0] enF    = en[1:0];
  wire        evtAny = crc6ErrorEvt | framingBitErrorEvt | txMsgStartEvt | rxMsgStartEvt | txMsgEndEvt
                     | rxMsgCompleteEvt | rxBufferFullEvt;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      phAddr <= 8'h00;
      en     <= 7'h00;
    end else begin
      if (wrPend && phAddr == 8'h04) en[1:0] <= hwdata[1:0];
      if (wrPend && phAddr == 8'h0C) en[6:3] <= hwdata[6:3];
      wrPend <= take && hwrite;
      rdPend <= take && !hwrite;
      if (take) phAddr <= haddr[7:0];
    end
  end
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence rdEnable;
    rdPend && phAddr == 8'h04;
  endsequence
  crc_irq_a: assert property (crc6ErrorEvt && en[1] && !enWr |=> irq)
    else $error("crc-6 error did not raise irq");
  fbe_irq_a: assert property (framingBitErrorEvt && en[0] && !enWr |=> irq)
    else $error("framing error did not raise irq");
  tx_start_irq_a: assert property (txMsgStartEvt && en[6] && !enWr |=> irq)
    else $error("transmit start did not raise irq");
  rx_end_irq_a: assert property (rxBufferFullEvt && en[3] && !enWr |=> irq)
    else $error("buffer full did not raise irq");
  rx_start_irq_a: assert property (rxMsgStartEvt && en[5] && !enWr |=> irq)
    else $error("receive start did not raise irq");
  tx_end_irq_a: assert property (txMsgEndEvt && en[4] && !enWr |=> irq)
    else $error("transmit end did not raise irq");
  no_enable_quiet_a: assert property (en == 7'h00 |-> !irq)
    else $error("irq high with every enable clear");
  enable_read_a: assert property (rdEnable |-> hrdata == {30'h0, $past(enF)})
    else $error("enable readback wrong");
  irq_cause_a: assert property ($rose(irq) |-> $past(evtAny) || $past(wrPend))
    else $error("irq rose without cause");
  rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
endmodule : fdis_chk

bind fdis_top fdis_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .crc6ErrorEvt(crc6ErrorEvt),
  .framingBitErrorEvt(framingBitErrorEvt), .txMsgStartEvt(txMsgStartEvt), .rxMsgStartEvt(rxMsgStartEvt),
  .txMsgEndEvt(txMsgEndEvt), .rxMsgCompleteEvt(rxMsgCompleteEvt), .rxBufferFullEvt(rxBufferFullEvt), .irq(irq));

// ### bench/fdis_tb_top.sv
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
module fdis_tb_top;
  import fdis_pkg::*;
  logic        mclk    = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [6:0]  evt     = 7'h00;
  logic        kind    = 1'b0;
  logic [31:0] rd;
  logic [31:0] m;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         irq;
  int          fails      = 0;
  int          n_compared = 0;
  always #12.5 mclk = ~mclk;
  fdis_top uut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .crc6ErrorEvt(evt[0]), .framingBitErrorEvt(evt[1]), .txMsgStartEvt(evt[2]), .rxMsgStartEvt(evt[3]),
    .txMsgEndEvt(evt[4]), .rxMsgCompleteEvt(evt[5]), .rxBufferFullEvt(evt[6]), .rxMsgKindIn(kind), .irq(irq));
  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // master holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic pulse(input logic [6:0] v);
    evt <= v;
    @(posedge mclk);
    evt <= 7'h00;
  endtask : pulse
  // irq is looked at mid-cycle where it has settled; the next request starts on a rising edge
  task automatic irqis(input logic exp);
    @(negedge mclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge mclk);
  endtask : irqis
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    irqis(1'b0);
    for (int a = 0; a < 8; a++) rdchk("reset value", 8'(a * 4), 32'h0);
    for (int b = 0; b < 2; b++) begin
      bus(1'b1, FRAMER_IRQ_ENABLE_OFS, 32'h0);
      pulse(7'(1 << b));
      irqis(1'b0);
      rdchk("framer status", FRAMER_STATUS_OFS, 32'(2 >> b));
      rdchk("framer status read again", FRAMER_STATUS_OFS, 32'h0);
      bus(1'b1, FRAMER_IRQ_ENABLE_OFS, 32'(2 >> b));
      rdchk("framer enable", FRAMER_IRQ_ENABLE_OFS, 32'(2 >> b));
      pulse(7'(1 << b));
      irqis(1'b1);
      rdchk("datalink untouched", DATALINK_STATUS_ONE_OFS, 32'h0);
      bus(1'b1, FRAMER_IRQ_ENABLE_OFS, 32'(1 << b));
      irqis(1'b0);
      rdchk("framer status kept", FRAMER_STATUS_OFS, 32'(2 >> b));
    end
    // every data link event, with the message kind latched on completion
    kind <= 1'b1;
    bus(1'b1, FRAMER_IRQ_ENABLE_OFS, 32'h0);
    for (int i = 2; i < 7; i++) begin
      m = 32'h1 << ((i < 6) ? 8 - i : 3);
      bus(1'b1, DATALINK_IRQ_EN_ONE_OFS, m);
      pulse(7'(1 << i));
      irqis(1'b1);
      rdchk("datalink status", DATALINK_STATUS_ONE_OFS, m | ((i > 4) ? 32'h80 : 32'h0));
      rdchk("datalink read again", DATALINK_STATUS_ONE_OFS, (i > 4) ? 32'h80 : 32'h0);
      irqis(1'b0);
    end
    kind <= 1'b0;
    pulse(7'h20);
    rdchk("bit-oriented kind", DATALINK_STATUS_ONE_OFS, 32'h08);
    // host refills on the start event, and is done before the end event
    pulse(7'h04);
    rdchk("tx start seen", DATALINK_STATUS_ONE_OFS, 32'h40);
    bus(1'b1, DATALINK_IRQ_EN_ONE_OFS, 32'h08);
    pulse(7'h10);
    rdchk("tx end seen", DATALINK_STATUS_ONE_OFS, 32'h10);
    // pending view, clear registers, read-only writes
    bus(1'b1, FRAMER_IRQ_ENABLE_OFS, 32'h3);
    bus(1'b1, DATALINK_IRQ_EN_ONE_OFS, 32'h78);
    pulse(7'h05);
    irqis(1'b1);
    rdchk("pending", IRQ_PENDING_OFS, 32'h3);
    bus(1'b1, FRAMER_CLEAR_OFS, 32'h3);
    irqis(1'b1);
    bus(1'b1, DATALINK_CLEAR_OFS, 32'h78);
    irqis(1'b0);
    bus(1'b1, FRAMER_STATUS_OFS, 32'hFFFFFFFF);
    rdchk("status after clear", DATALINK_STATUS_ONE_OFS, 32'h0);
    rdchk("enable kept", FRAMER_IRQ_ENABLE_OFS, 32'h3);
    results;
  end
  // a hang costs far more than the roughly 160 cycles the tests need
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    results;
  end
endmodule : fdis_tb_top
